// >>> core/fts_status_core.sv
// Threshold counters and host/slave status with freeze-mode shadows.
// Assumes the surrounding FIFO delivers one-cycle access pulses, full and
// empty levels from its pointers, and the freeze-mode level.
//
// How it works
// - Host write decrements, CPU read increments input
// - CPU write decrements, host read increments output
// - Counter top bit is service request
// - CPU writes thresholds only while frozen
// - Input threshold top bit drives host request
// - Freeze forces host bits, shadows keep truth
// - Invalid host output read clears output error
// - Outgoing command status: CPU write clears, host sets
// - Output marker forced while frozen, shadow meanwhile
// - Frozen host writes clear input error
// - Incoming command status with frozen shadow
// - Host freeze indicator high while frozen
// - Slave output overrun held while frozen
// - Frozen CPU outgoing command read/write status
// - Slave freeze bit low while frozen
// - Slave output request from output pointers
// - Input underrun: empty read clears, status read sets
// - Slave incoming command status in both modes
// - Input marker flag; mismatched read gives invalid
// - Slave input request from input pointers only
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none

module fts_status_core
    import fts_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [FTS_ADR_W-1:0] paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Mode and FIFO levels
    input  wire logic                 freezeMode,
    input  wire logic                 inFifoEmpty,
    input  wire logic                 inFifoFull,
    input  wire logic                 outFifoFull,
    input  wire logic                 outFifoEmpty,
    input  wire logic                 inHeadIsCmd,
    input  wire logic                 outHeadIsCmd,
    input  wire logic [7:0]           inHeadByte,
    // Host accesses
    input  wire logic                 hostWrInFifo,
    input  wire logic                 hostRdOutFifo,
    input  wire logic                 hostRdOutCmd,
    input  wire logic                 hostWrInCmd,
    input  wire logic                 hostWrHostCtrl,
    input  wire logic                 hostRdHostStat,
    // Internal CPU accesses
    input  wire logic                 cpuRdInFifo,
    input  wire logic                 cpuRdViaCmdReg,
    input  wire logic                 cpuWrOutFifo,
    input  wire logic                 cpuWrOutCmd,
    input  wire logic                 cpuRdOutCmd,
    input  wire logic                 cpuWrInCmd,
    input  wire logic                 cpuRdInCmd,
    // Results
    output logic      [7:0]           hostStatusView,
    output logic      [7:0]           cpuInByte,
    output logic                      inThrReq,
    output logic                      outThrReq
);

    typedef struct packed {
        logic [7:0]  hostShadow;
        logic [7:0]  slvStat;
        logic [7:0]  hostView;
        logic [7:0]  inByte;
        logic [31:0] rdata;
        logic        ready;
        logic        slvErr;
        logic        inReq;
        logic        outReq;
    } fts_state_t;

    localparam fts_state_t FTS_STATE_RST = '{
        hostShadow: FTS_HOST_RST,
        slvStat:    FTS_SLV_RST,
        hostView:   FTS_HOST_RST,
        inByte:     FTS_INVALID_BYTE,
        rdata:      FTS_RDATA_RST,
        ready:      1'b0,
        slvErr:     1'b0,
        inReq:      1'b0,
        outReq:     1'b0
    };

    fts_state_t state_ff;
    fts_state_t nxt_state;

    logic [FTS_REG_W-1:0] thrCount [FTS_NUM_CH];
    logic [FTS_NUM_CH-1:0] thrDec;
    logic [FTS_NUM_CH-1:0] thrInc;
    logic [FTS_NUM_CH-1:0] thrLoad;

    logic       apbDone;
    logic       apbWrDone;
    logic       apbRdDone;
    logic       hitInThr;
    logic       hitOutThr;
    logic       hitHost;
    logic       hitSlv;
    logic       hitView;
    logic       hitAny;

    // APB: access phase lasts two cycles, pready from a flop
    // Writes land only on the edge that also shows pready high
    assign apbDone   = psel && penable && state_ff.ready;
    assign apbWrDone = apbDone && pwrite;
    assign apbRdDone = apbDone && !pwrite;

    // Unaligned or unknown offsets answer with an error
    always_comb begin
        hitInThr  = 1'b0;
        hitOutThr = 1'b0;
        hitHost   = 1'b0;
        hitSlv    = 1'b0;
        hitView   = 1'b0;
        if (paddr == FTS_OFF_IN_THR) begin
            hitInThr = 1'b1;
        end else if (paddr == FTS_OFF_OUT_THR) begin
            hitOutThr = 1'b1;
        end else if (paddr == FTS_OFF_HOST_STAT) begin
            hitHost = 1'b1;
        end else if (paddr == FTS_OFF_SLV_STAT) begin
            hitSlv = 1'b1;
        end else if (paddr == FTS_OFF_HOST_VIEW) begin
            hitView = 1'b1;
        end
        hitAny = hitInThr || hitOutThr || hitHost || hitSlv || hitView;
    end

    // Counter events; host FIFO accesses are refused while frozen
    // The host port is cut off then, so it must not move the counts
    always_comb begin
        thrDec = '0;
        thrInc = '0;
        thrLoad = '0;
        thrDec[FTS_CH_IN]  = hostWrInFifo && !freezeMode;
        thrInc[FTS_CH_IN]  = cpuRdInFifo;
        thrDec[FTS_CH_OUT] = cpuWrOutFifo;
        thrInc[FTS_CH_OUT] = hostRdOutFifo && !freezeMode;
        // Threshold writes only take while frozen
        thrLoad[FTS_CH_IN]  = apbWrDone && hitInThr && freezeMode;
        thrLoad[FTS_CH_OUT] = apbWrDone && hitOutThr && freezeMode;
    end

    // One counter per channel; a load beats both count events
    generate
        for (genvar ch = 0; ch < FTS_NUM_CH; ch++) begin : g_thr
            fts_thr_counter #(
                .W (FTS_REG_W)
            ) u_thr (
                .core_clk (core_clk),
                .nrst     (nrst),
                .decEvt   (thrDec[ch]),
                .incEvt   (thrInc[ch]),
                .loadEn   (thrLoad[ch]),
                .loadVal  (pwdata[FTS_REG_W-1:0]),
                .count    (thrCount[ch])
            );
        end
    endgenerate

    always_comb begin
        logic [7:0] hs;
        logic [7:0] ss;
        logic       frz;
        hs  = state_ff.hostShadow;
        ss  = state_ff.slvStat;
        frz = freezeMode;
        nxt_state = state_ff;

        // Error and overrun flags: restore first, so a new event wins
        if (hostRdHostStat) begin
            hs[HST_OUT_ERR] = 1'b1;
            hs[HST_IN_ERR]  = 1'b1;
        end
        if (apbRdDone && hitSlv && !frz) begin
            ss[SST_IN_UNR]  = 1'b1;
            ss[SST_OUT_OVR] = 1'b1;
        end

        // Output error: invalid host read
        if (frz) begin
            if (hostRdOutFifo || hostRdOutCmd) begin
                hs[HST_OUT_ERR] = 1'b0;
            end
        end else if (hostRdOutFifo && outFifoEmpty) begin
            hs[HST_OUT_ERR] = 1'b0;
        end

        // Input error: overrun normally, any host write while frozen
        if (frz) begin
            if (hostWrInFifo || hostWrHostCtrl || hostWrInCmd) begin
                hs[HST_IN_ERR] = 1'b0;
            end
        end else if (hostWrInFifo && inFifoFull) begin
            hs[HST_IN_ERR] = 1'b0;
        end

        // Outgoing command status
        if (frz) begin
            if (cpuWrOutCmd) begin
                hs[HST_OUT_CMD] = 1'b0;
                ss[SST_OUT_CMD] = 1'b1;
            end else if (cpuRdOutCmd) begin
                hs[HST_OUT_CMD] = 1'b1;
                ss[SST_OUT_CMD] = 1'b0;
            end
        end else begin
            if (cpuWrOutCmd) begin
                hs[HST_OUT_CMD] = 1'b0;
                ss[SST_OUT_CMD] = 1'b1;
            end else if (hostRdOutCmd) begin
                hs[HST_OUT_CMD] = 1'b1;
                ss[SST_OUT_CMD] = 1'b0;
            end
        end

        // Incoming command status
        if (frz) begin
            if (cpuWrInCmd) begin
                hs[HST_IN_CMD] = 1'b1;
                ss[SST_IN_CMD] = 1'b0;
            end else if (cpuRdInCmd) begin
                hs[HST_IN_CMD] = 1'b0;
                ss[SST_IN_CMD] = 1'b1;
            end
        end else begin
            if (hostWrInCmd) begin
                hs[HST_IN_CMD] = 1'b1;
                ss[SST_IN_CMD] = 1'b0;
            end else if (cpuRdInCmd) begin
                hs[HST_IN_CMD] = 1'b0;
                ss[SST_IN_CMD] = 1'b1;
            end
        end

        // Output overrun: CPU write to a full output FIFO
        if (!frz && cpuWrOutFifo && outFifoFull) begin
            ss[SST_OUT_OVR] = 1'b0;
        end

        // Input underrun: CPU read of an empty input FIFO
        if (!frz && cpuRdInFifo && inFifoEmpty) begin
            ss[SST_IN_UNR] = 1'b0;
        end

        // Level bits follow live state in both modes
        // Freeze masking touches only the host copy, further down
        hs[HST_OUT_MRK] = !outHeadIsCmd;
        hs[HST_OUT_REQ] = !thrCount[FTS_CH_OUT][FTS_THR_REQ_BIT];
        hs[HST_IN_REQ]  = !thrCount[FTS_CH_IN][FTS_THR_REQ_BIT];
        hs[HST_FRZ]     = frz;
        ss[SST_FRZ]     = !frz;
        ss[SST_OUT_REQ] = outFifoFull;
        ss[SST_IN_MRK]  = !inHeadIsCmd;
        ss[SST_IN_REQ]  = inFifoEmpty;

        nxt_state.hostShadow = hs;
        nxt_state.slvStat    = ss;

        // Host sees forced ones while frozen; shadow keeps the truth
        // Leaving freeze restores the true bits at the next edge
        if (frz) begin
            nxt_state.hostView = hs | FTS_HOST_FRZ_MASK;
        end else begin
            nxt_state.hostView = hs;
        end

        // Mismatched kind of read yields the invalid byte
        // A byte of the wrong kind is never handed over as valid
        if (cpuRdInFifo) begin
            if (inHeadIsCmd != cpuRdViaCmdReg) begin
                nxt_state.inByte = FTS_INVALID_BYTE;
            end else begin
                nxt_state.inByte = inHeadByte;
            end
        end

        // Requests lag the counters by one edge
        nxt_state.inReq  = thrCount[FTS_CH_IN][FTS_THR_REQ_BIT];
        nxt_state.outReq = thrCount[FTS_CH_OUT][FTS_THR_REQ_BIT];

        // APB answer one cycle into the access phase
        // The pulse drops on its own, so each access gets exactly one
        nxt_state.ready  = psel && penable && !state_ff.ready;
        nxt_state.slvErr = 1'b0;
        if (psel && penable && !state_ff.ready) begin
            nxt_state.slvErr = !hitAny;
            nxt_state.rdata  = FTS_RDATA_RST;
            // Reads return last-edge state, not this cycle's updates
            if (!pwrite) begin
                if (hitInThr) begin
                    nxt_state.rdata[7:0] = thrCount[FTS_CH_IN];
                end else if (hitOutThr) begin
                    nxt_state.rdata[7:0] = thrCount[FTS_CH_OUT];
                end else if (hitHost) begin
                    nxt_state.rdata[7:0] = state_ff.hostShadow;
                end else if (hitSlv) begin
                    nxt_state.rdata[7:0] = state_ff.slvStat;
                end else if (hitView) begin
                    nxt_state.rdata[7:0] = state_ff.hostView;
                end
            end
        end
    end

    // Status, view and bus answer bits all leave from this register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= FTS_STATE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Every output is a flop output
    assign prdata         = state_ff.rdata;
    assign pready         = state_ff.ready;
    assign pslverr        = state_ff.slvErr;
    assign hostStatusView = state_ff.hostView;
    assign cpuInByte      = state_ff.inByte;
    assign inThrReq       = state_ff.inReq;
    assign outThrReq      = state_ff.outReq;

endmodule : fts_status_core

`default_nettype wire

// >>> core/fts_pkg.sv
// Shared constants for the FIFO threshold and status-freeze block.
// Assumes a 32-bit APB slave and 8-bit status and threshold registers.
`default_nettype none

package fts_pkg;

    // APB byte offsets
    localparam logic [7:0] FTS_OFF_IN_THR    = 8'h00;
    localparam logic [7:0] FTS_OFF_OUT_THR   = 8'h04;
    localparam logic [7:0] FTS_OFF_HOST_STAT = 8'h08;
    localparam logic [7:0] FTS_OFF_SLV_STAT  = 8'h0C;
    localparam logic [7:0] FTS_OFF_HOST_VIEW = 8'h10;

    // Widths
    localparam int FTS_REG_W = 8;
    localparam int FTS_ADR_W = 8;
    localparam int FTS_NUM_CH = 2;
    localparam int FTS_CH_IN  = 0;
    localparam int FTS_CH_OUT = 1;

    // Threshold counter sign bit is the service request
    localparam int FTS_THR_REQ_BIT = 7;

    // Host status bit positions
    localparam int HST_OUT_ERR  = 7;
    localparam int HST_OUT_CMD  = 6;
    localparam int HST_OUT_MRK  = 5;
    localparam int HST_OUT_REQ  = 4;
    localparam int HST_IN_ERR   = 3;
    localparam int HST_IN_CMD   = 2;
    localparam int HST_FRZ      = 1;
    localparam int HST_IN_REQ   = 0;

    // Slave status bit positions
    localparam int SST_OUT_OVR  = 7;
    localparam int SST_OUT_CMD  = 6;
    localparam int SST_FRZ      = 5;
    localparam int SST_OUT_REQ  = 4;
    localparam int SST_IN_UNR   = 3;
    localparam int SST_IN_CMD   = 2;
    localparam int SST_IN_MRK   = 1;
    localparam int SST_IN_REQ   = 0;

    // Bits presented as 1 to the host while frozen
    localparam logic [7:0] FTS_HOST_FRZ_MASK = 8'hF5;

    // Reset values
    localparam logic [7:0] FTS_THR_RST      = 8'h00;
    localparam logic [7:0] FTS_HOST_RST     = 8'hFF;
    localparam logic [7:0] FTS_SLV_RST      = 8'hFF;
    localparam logic [7:0] FTS_INVALID_BYTE = 8'hFF;
    localparam logic [31:0] FTS_RDATA_RST   = 32'h0000_0000;

endpackage : fts_pkg

`default_nettype wire

// >>> core/fts_thr_counter.sv
// One threshold counter: counts down on fills, up on drains.
// Assumes single-cycle event pulses synchronous to core_clk.
`default_nettype none

module fts_thr_counter
    import fts_pkg::*;
#(
    parameter int W = FTS_REG_W
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic         decEvt,
    input  wire logic         incEvt,
    input  wire logic         loadEn,
    input  wire logic [W-1:0] loadVal,
    output logic      [W-1:0] count
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } fts_cnt_state_t;

    fts_cnt_state_t state_ff;
    fts_cnt_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (loadEn) begin
            nxt_state.cnt = loadVal;
        end else if (decEvt && !incEvt) begin
            nxt_state.cnt = state_ff.cnt - W'(1);
        end else if (incEvt && !decEvt) begin
            nxt_state.cnt = state_ff.cnt + W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '{cnt: W'(FTS_THR_RST)};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign count = state_ff.cnt;

endmodule : fts_thr_counter

`default_nettype wire

// >>> bench/fts_checker.sv
// Concurrent checks on the status core ports.
// Assumes it is bound into fts_status_core from the bench top.
`default_nettype none
module fts_checker
    import fts_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        freezeMode,
    input wire logic        cpuRdInFifo,
    input wire logic        cpuRdViaCmdReg,
    input wire logic        inHeadIsCmd,
    input wire logic [7:0]  inHeadByte,
    input wire logic [7:0]  hostStatusView,
    input wire logic [7:0]  cpuInByte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] liveCnt_ff;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            liveCnt_ff <= 2'h0;
        end else if (liveCnt_ff != 2'h3) begin
            liveCnt_ff <= liveCnt_ff + 2'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence sAcc;
        psel && penable && !pready;
    endsequence
    sequence sFrozen;
        freezeMode && $past(freezeMode) && $past(freezeMode, 2);
    endsequence
    a_apb_one_wait: assert property (sAcc |=> pready)
        else $error("ready missing after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (
        sAcc ##0 paddr > FTS_OFF_HOST_VIEW |=> pslverr)
        else $error("no error for unmapped address");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_frz_host_ones: assert property (sFrozen |->
        (hostStatusView & FTS_HOST_FRZ_MASK) == FTS_HOST_FRZ_MASK)
        else $error("frozen host bits not forced");
    a_host_frz_bit: assert property (
        liveCnt_ff == 2'h3 ##0 sFrozen |-> hostStatusView[HST_FRZ])
        else $error("freeze indicator low while frozen");
    a_host_norm_bit: assert property (
        liveCnt_ff == 2'h3 && !freezeMode && !$past(freezeMode)
        && !$past(freezeMode, 2) |-> !hostStatusView[HST_FRZ])
        else $error("freeze indicator high in normal mode");
    a_slv_frz_low: assert property (sAcc ##0 !pwrite
        && paddr == FTS_OFF_SLV_STAT ##0 sFrozen |=> !prdata[SST_FRZ])
        else $error("slave freeze bit high while frozen");
    a_mark_mismatch: assert property (
        cpuRdInFifo && inHeadIsCmd != cpuRdViaCmdReg
        |=> cpuInByte == FTS_INVALID_BYTE)
        else $error("mismatched read not invalid");
    a_data_pass: assert property (
        cpuRdInFifo && !inHeadIsCmd && !cpuRdViaCmdReg
        |=> cpuInByte == $past(inHeadByte))
        else $error("data byte not returned");
endmodule : fts_checker
`default_nettype wire

// >>> bench/fts_host_model.sv
// External host model: one-cycle access pulses into the core.
// Assumes the bench calls access with a gap of at least one cycle.
`default_nettype none
module fts_host_model (
    input  wire logic core_clk,
    output logic      hostWrInFifo,
    output logic      hostRdOutFifo,
    output logic      hostRdOutCmd,
    output logic      hostWrInCmd,
    output logic      hostWrHostCtrl,
    output logic      hostRdHostStat
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] pulseVec = 6'h00;
    assign hostWrInFifo   = pulseVec[0];
    assign hostRdOutFifo  = pulseVec[1];
    assign hostRdOutCmd   = pulseVec[2];
    assign hostWrInCmd    = pulseVec[3];
    assign hostWrHostCtrl = pulseVec[4];
    assign hostRdHostStat = pulseVec[5];
    // A gap above one models a slow host
    task automatic access(input int kind, input int gap);
        repeat (gap) @(posedge core_clk);
        pulseVec <= 6'h01 << kind;
        @(posedge core_clk);
        pulseVec <= 6'h00;
    endtask : access
endmodule : fts_host_model
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the threshold and status-freeze core.
// Assumes fts_pkg, the core, checker and host model compile first.
`default_nettype none
module tb_top
    import fts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic        freezeMode, inFifoEmpty, outFifoFull, inHeadIsCmd;
    logic        inFifoFull, outFifoEmpty, outHeadIsCmd;
    logic        inThrReq, outThrReq, v, c, e;
    logic [7:0]  paddr, inHeadByte, hostStatusView, cpuInByte;
    logic [31:0] pwdata, prdata, rdat;
    logic [6:0]  cpuEv;
    wire  [5:0]  hostEv;
    int          failures, comparisons, cyc, inCnt, outCnt;
    int          hk[4] = '{2, 3, 4, 0};
    int          ck[4] = '{5, 6, 3, 4};

    fts_host_model fts_host_model_inst (.core_clk(core_clk),
        .hostWrInFifo(hostEv[0]), .hostRdOutFifo(hostEv[1]),
        .hostRdOutCmd(hostEv[2]), .hostWrInCmd(hostEv[3]),
        .hostWrHostCtrl(hostEv[4]), .hostRdHostStat(hostEv[5]));
    fts_status_core fts_status_core_inst (.core_clk(core_clk),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .freezeMode(freezeMode),
        .inFifoEmpty(inFifoEmpty), .inFifoFull(inFifoFull),
        .outFifoFull(outFifoFull), .outFifoEmpty(outFifoEmpty),
        .inHeadIsCmd(inHeadIsCmd), .outHeadIsCmd(outHeadIsCmd),
        .inHeadByte(inHeadByte), .hostWrInFifo(hostEv[0]),
        .hostRdOutFifo(hostEv[1]), .hostRdOutCmd(hostEv[2]),
        .hostWrInCmd(hostEv[3]), .hostWrHostCtrl(hostEv[4]),
        .hostRdHostStat(hostEv[5]), .cpuRdInFifo(cpuEv[0]),
        .cpuRdViaCmdReg(cpuEv[1]), .cpuWrOutFifo(cpuEv[2]),
        .cpuWrOutCmd(cpuEv[3]), .cpuRdOutCmd(cpuEv[4]),
        .cpuWrInCmd(cpuEv[5]), .cpuRdInCmd(cpuEv[6]),
        .hostStatusView(hostStatusView), .cpuInByte(cpuInByte),
        .inThrReq(inThrReq), .outThrReq(outThrReq));

    always #4 core_clk = ~core_clk;

    task automatic end_sim;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask : tick

    // Setup, then access held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1 && cyc < 20000);
        rdat = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cpu(input logic [6:0] ev);
        @(posedge core_clk);
        cpuEv <= ev;
        @(posedge core_clk);
        cpuEv <= 7'h00;
    endtask : cpu

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        freezeMode = 1'b0;
        inFifoEmpty = 1'b1;
        outFifoFull = 1'b0;
        inFifoFull = 1'b0;
        outFifoEmpty = 1'b0;
        outHeadIsCmd = 1'b0;
        inHeadIsCmd = 1'b0;
        inHeadByte = 8'h00;
        cpuEv = 7'h00;
        void'($urandom(53552));
        tick(20);
        chk({hostStatusView, cpuInByte}, 16'hFFFF);
        nrst <= 1'b1;
        apb(1'b0, FTS_OFF_OUT_THR, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(e, 1'b1);
        cpu(7'h01);
        inCnt++;
        apb(1'b0, FTS_OFF_SLV_STAT, 32'h0);
        chk(rdat[SST_IN_UNR], 1'b0);
        apb(1'b0, FTS_OFF_SLV_STAT, 32'h0);
        chk(rdat[SST_IN_UNR], 1'b1);
        apb(1'b1, FTS_OFF_IN_THR, 32'h55);
        apb(1'b0, FTS_OFF_IN_THR, 32'h0);
        chk(rdat, inCnt);
        freezeMode <= 1'b1;
        tick(3);
        inCnt = 8'h80 | ($urandom % 8);
        outCnt = 2 + $urandom % 8;
        apb(1'b1, FTS_OFF_IN_THR, inCnt);
        apb(1'b1, FTS_OFF_OUT_THR, outCnt);
        apb(1'b0, FTS_OFF_IN_THR, 32'h0);
        chk(rdat, inCnt);
        foreach (ck[i]) begin
            e = (ck[i] == 3 || ck[i] == 6);
            v = e;
            cpu(7'h01 << ck[i]);
            apb(1'b0, FTS_OFF_SLV_STAT, 32'h0);
            chk(rdat[ck[i] > 4 ? SST_IN_CMD : SST_OUT_CMD], v);
            apb(1'b0, FTS_OFF_HOST_STAT, 32'h0);
            chk(rdat[ck[i] > 4 ? HST_IN_CMD : HST_OUT_CMD], !v);
        end
        foreach (hk[i]) begin
            fts_host_model_inst.access(5, 1);
            fts_host_model_inst.access(hk[i], 2);
            tick(2);
            apb(1'b0, FTS_OFF_HOST_STAT, 32'h0);
            chk(rdat & 8'h88, hk[i] == 2 ? 8'h08 : 8'h80);
        end
        freezeMode <= 1'b0;
        inFifoEmpty <= 1'b0;
        tick(3);
        chk(hostStatusView[HST_IN_REQ], !inCnt[7]);
        for (int r = 0; r < 6; r++) begin
            repeat ($urandom % 4) begin
                fts_host_model_inst.access(0, 1 + $urandom % 3);
                inCnt--;
            end
            repeat ($urandom % 4) begin
                v = $urandom % 2;
                c = $urandom % 2;
                inHeadIsCmd <= c;
                inHeadByte <= 8'($urandom);
                cpu({5'h00, v, 1'b1});
                inCnt++;
                tick(1);
                chk(cpuInByte, c != v ? FTS_INVALID_BYTE : inHeadByte);
            end
            repeat ($urandom % 4) begin
                cpu(7'h04);
                outCnt--;
            end
            repeat ($urandom % 4) begin
                fts_host_model_inst.access(1, 1 + $urandom % 3);
                outCnt++;
            end
            tick(3);
            apb(1'b0, FTS_OFF_IN_THR, 32'h0);
            chk(rdat, inCnt & 8'hFF);
            apb(1'b0, FTS_OFF_OUT_THR, 32'h0);
            chk(rdat, outCnt & 8'hFF);
            chk({inThrReq, outThrReq}, {inCnt[7], outCnt[7]});
            chk(hostStatusView[HST_IN_REQ], !inCnt[7]);
        end
        repeat (4) begin
            v = $urandom % 2;
            c = $urandom % 2;
            inFifoEmpty <= v;
            outFifoFull <= c;
            tick(3);
            apb(1'b0, FTS_OFF_SLV_STAT, 32'h0);
            chk(rdat[SST_IN_REQ], v);
            chk(rdat[SST_OUT_REQ], c);
        end
        // Normal-mode command handshakes, error and overrun flags, then overrun held while frozen
        fts_host_model_inst.access(5, 1);
        cpu(7'h08);
        fts_host_model_inst.access(3, 1);
        tick(2);
        chk(hostStatusView & 8'hEC, 8'hAC);
        apb(1'b0, FTS_OFF_SLV_STAT, 32'h0);
        chk(rdat & 8'h44, 8'h40);
        fts_host_model_inst.access(2, 1);
        cpu(7'h40);
        outFifoEmpty <= 1'b1;
        inFifoFull <= 1'b1;
        outFifoFull <= 1'b1;
        outHeadIsCmd <= 1'b1;
        fts_host_model_inst.access(1, 1);
        fts_host_model_inst.access(0, 1);
        cpu(7'h04);
        tick(2);
        chk(hostStatusView & 8'hEC, 8'h40);
        apb(1'b0, FTS_OFF_SLV_STAT, 32'h0);
        chk(rdat & 8'hE4, 8'h24);
        freezeMode <= 1'b1;
        tick(3);
        cpu(7'h04);
        apb(1'b0, FTS_OFF_SLV_STAT, 32'h0);
        chk(rdat & 8'hA0, 8'h80);
        freezeMode <= 1'b0;
        tick(3);
        chk(hostStatusView & 8'hEC, 8'h40);
        end_sim();
    end
endmodule : tb_top

bind fts_status_core fts_checker fts_checker_inst (.core_clk, .nrst,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .freezeMode, .cpuRdInFifo, .cpuRdViaCmdReg, .inHeadIsCmd,
    .inHeadByte, .hostStatusView, .cpuInByte);
`default_nettype wire
